//--- dv/ssdc_checker.sv
// Purpose: Port-level assertions for the sync and reference divider control.
// Assumes: Registers change only at the ack edge of a write.
// Notes:   Shadows the control and block bits seen on the bus.
`timescale 1ns/100ps
`default_nettype none
module ssdc_checker
    import ssdc_pkg::*;
#(
    parameter int NPAIRS = 7
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              cyc_i,
    input wire logic              stb_i,
    input wire logic              we_i,
    input wire logic [7:0]        adr_i,
    input wire logic [3:0]        sel_i,
    input wire logic [31:0]       dat_i,
    input wire logic [31:0]       dat_o,
    input wire logic              ack_o,
    input wire logic              sync_pin_i,
    input wire logic              dist_clk_active_i,
    input wire logic [NPAIRS-1:0] pair_divider_reset_o,
    input wire logic              ref_divider_reset_o,
    input wire logic              ref_divider_tick_o,
    input wire logic              sync_path_o,
    input wire logic              ref_delay_buffer_clear_o
);
    logic [7:0]        ctl;
    logic [NPAIRS-1:0] blk;
    logic              ref_blk;
    wire               wr = ack_o && we_i && cyc_i;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl <= 8'h40;
            blk <= '1;
            ref_blk <= 1'b1;
        end else if (wr && adr_i == SSDC_ADR_CTRL && sel_i[0]) begin
            ctl <= dat_i[7:0];
        end else if (wr && adr_i == SSDC_ADR_BLOCK) begin
            blk <= sel_i[0] ? dat_i[NPAIRS-1:0] : blk;
            ref_blk <= sel_i[2] ? dat_i[16] : ref_blk;
        end
    end

    sequence s_request;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_pin_rise;
        $rose(sync_pin_i) && ctl[5:0] == 6'h05 && ctl[7:6] != SSDC_ROUTE_SYNC && dist_clk_active_i;
    endsequence

    a_ack_next: assert property (s_request |=> ack_o)
        else $error("ack missing one cycle after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_unmapped_zero: assert property (ack_o && !we_i && adr_i > SSDC_ADR_RATE |-> dat_o == 0)
        else $error("unmapped read not zero");
    a_clear_reset: assert property ($fell(rst_i) |-> ref_delay_buffer_clear_o)
        else $error("buffer clear low after reset");
    a_enable_gate: assert property (!ctl[0] && !$past(ctl[0]) |-> !(|pair_divider_reset_o))
        else $error("divider reset while sync disabled");
    a_pair_gate: assert property ($stable(ctl) && $stable(blk)
        |-> pair_divider_reset_o == ({NPAIRS{sync_path_o && ctl[0]}} & ~blk))
        else $error("pair divider reset differs from path");
    a_ref_gate: assert property ($stable(ctl) && $stable(ref_blk)
        |-> ref_divider_reset_o == (sync_path_o && ctl[0] && !ref_blk))
        else $error("reference divider reset differs from path");
    a_no_clock: assert property (!dist_clk_active_i [*4] |-> !sync_path_o)
        else $error("path active without distribution clock");
    a_pin_path: assert property (s_pin_rise |-> ##[2:3] sync_path_o)
        else $error("pin did not reach path");
    a_tick_pulse: assert property (ref_divider_tick_o |=> !ref_divider_tick_o)
        else $error("divider tick longer than one cycle");
endmodule // ssdc_checker
bind ssdc_top ssdc_checker #(.NPAIRS(NPAIRS)) chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .sync_pin_i, .dist_clk_active_i,
    .pair_divider_reset_o, .ref_divider_reset_o, .ref_divider_tick_o, .sync_path_o,
    .ref_delay_buffer_clear_o);
`default_nettype wire

//--- dv/ssdc_host_model.sv
// Purpose: Host that programs the block over Wishbone and drives its pins.
// Assumes: Requests start just after a rising edge and wait for ack.
// Notes:   Released address and data lines show inverted values; cyc, stb and we drop to 0.
`timescale 1ns/100ps
`default_nettype none
module ssdc_host_model
    import ssdc_pkg::*;
(
    // Bus and pins.
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [31:0]      dat_o,
    output logic             pin_o,
    output logic             zero_o
);
    logic hung = 1'b0;
    initial begin
        {cyc_o, stb_o, we_o, pin_o, zero_o} = 5'h00;
        adr_o = 8'hFF;
        dat_o = 32'hA5A5_5A5A;
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge clk_i);
        {cyc_o, stb_o, we_o} <= {2'b11, w};
        adr_o <= a;
        dat_o <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 64);
        hung |= (n >= 64);
        q = dat_i;
        {cyc_o, stb_o, we_o} <= 3'b000;
        adr_o <= ~a;
        dat_o <= ~d;
    endtask
    task automatic pulse(input logic zero, input int len);
        @(posedge clk_i);
        {zero_o, pin_o} <= {zero, !zero};
        repeat (len) @(posedge clk_i);
        {zero_o, pin_o} <= 2'b00;
    endtask
    // Powers the reference block, generator, delays and pair outputs, then holds the clear.
    task automatic startup;
        logic [31:0] q;
        wb(1'b1, SSDC_ADR_POWER, 32'h0, q);
        wb(1'b1, SSDC_ADR_PAIRS, 32'h0000_5555, q);
        repeat (15) @(posedge clk_i);
        // Divide values stay at defaults and delays stay powered afterwards.
    endtask
endmodule // ssdc_host_model
`default_nettype wire

//--- dv/ssdc_top_test.sv
// Purpose: Self-checking bench for the sync and reference divider control.
// Assumes: One 125 MHz clock; reference divide set to 4 for short runs.
// Notes:   Counts path rises to judge syncs, bursts and streams.
`timescale 1ns/100ps
`default_nettype none
module ssdc_top_test;
    import ssdc_pkg::*;
    localparam int NP = 7;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sync_pin_i, reference_input_zero_i;
    logic dist_clk_active_i, ref_divider_reset_o, ref_divider_tick_o, sync_path_o;
    logic ref_out_o, ref_delay_buffer_clear_o;
    logic [7:0] adr_i;
    logic [31:0] dat_i, dat_o;
    logic [NP-1:0] pair_divider_reset_o, pair_ref_out_o;
    int num_errors = 0;
    int total_checks = 0;
    logic [NP-1:0] pair_seen;
    logic ref_seen;
    logic [31:0] seed = 32'h0000_97FF;

    ssdc_top #(.NPAIRS(NP)) dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .sync_pin_i, .reference_input_zero_i,
        .dist_clk_active_i, .pair_divider_reset_o, .ref_divider_reset_o, .ref_divider_tick_o,
        .sync_path_o, .ref_out_o, .pair_ref_out_o, .ref_delay_buffer_clear_o);
    ssdc_host_model host_u (.clk_i, .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i),
        .we_o(we_i), .adr_o(adr_i), .dat_o(dat_i), .pin_o(sync_pin_i),
        .zero_o(reference_input_zero_i));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] burst_pulses(input logic [1:0] v);
        return 32'h1 << v;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        total_checks++;
        if (got !== want) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic watch(input int n, output logic [31:0] cnt, output logic [NP-1:0] seen);
        logic prev;
        cnt = 0;
        seen = '0;
        pair_seen = '0;
        ref_seen = 1'b0;
        prev = sync_path_o;
        repeat (n) begin
            @(posedge clk_i);
            #1;
            cnt += (sync_path_o === 1'b1 && prev !== 1'b1);
            seen |= sync_path_o === 1'b1 ? pair_divider_reset_o : '0;
            pair_seen |= pair_ref_out_o;
            ref_seen |= ref_out_o;
            prev = sync_path_o;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host_u.wb(1'b1, a, d, q);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        print_verdict;
    end
    initial begin
        logic [7:0] adrs[4] = '{SSDC_ADR_CTRL, SSDC_ADR_POWER, SSDC_ADR_BLOCK, SSDC_ADR_RATE};
        logic [31:0] rsts[4] = '{SSDC_CTRL_RST, SSDC_POWER_RST, 32'hFFFF_FFFF, 32'(SSDC_RATE_RST)};
        logic [31:0] q, c;
        logic [NP-1:0] s;
        rst_i = 1'b1;
        dist_clk_active_i = 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        check(32'(ref_delay_buffer_clear_o), 1);
        for (int i = 0; i < 4; i++) begin
            host_u.wb(1'b0, adrs[i], 32'h0, q);
            check(q, rsts[i]);
        end
        wr(8'h1C, 32'hFFFF_FFFF);
        host_u.wb(1'b0, 8'h1C, 32'h0, q);
        check(q, SSDC_UNMAPPED);
        host_u.startup;
        wr(SSDC_ADR_RATE, 32'h4);
        wr(SSDC_ADR_BLOCK, 32'h0);
        wr(SSDC_ADR_CTRL, 32'h45);
        repeat (2) @(posedge clk_i);
        check(32'(ref_delay_buffer_clear_o), 0);
        wr(SSDC_ADR_CTRL, 32'h47);
        watch(12, c, s);
        check(c, 1);
        check(32'(pair_seen), 32'h55);
        check(32'(ref_seen), 1);
        check(32'(s), 32'h7F);
        wr(SSDC_ADR_CTRL, 32'h45);
        watch(12, c, s);
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            wr(SSDC_ADR_BLOCK, 32'h0001_0000 | 32'(seed[6:0]));
            fork host_u.pulse(1'b0, 3 + 32'(seed[10:8])); watch(30, c, s); join
            check(c, 1);
            check(32'(s), {25'h0, ~seed[6:0]});
        end
        wr(SSDC_ADR_CTRL, 32'h44);
        fork host_u.pulse(1'b0, 4); watch(20, c, s); join
        check(32'(s), 0);
        wr(SSDC_ADR_CTRL, 32'h45);
        dist_clk_active_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        fork host_u.pulse(1'b0, 4); watch(20, c, s); join
        check(c, 0);
        dist_clk_active_i <= 1'b1;
        wr(SSDC_ADR_CTRL, 32'h05);
        fork host_u.pulse(1'b1, 4); watch(20, c, s); join
        check(c, 1);
        wr(SSDC_ADR_CTRL, 32'h6D);
        for (int v = 0; v < 4; v++) begin
            wr(SSDC_ADR_BURST, 32'(v));
            watch(60, c, s);
            check(c, burst_pulses(v[1:0]));
        end
        wr(SSDC_ADR_CTRL, 32'h69);
        wr(SSDC_ADR_BURST, 32'h1);
        fork host_u.pulse(1'b0, 60); watch(60, c, s); join
        check(c, burst_pulses(2'h1));
        watch(60, c, s);
        wr(SSDC_ADR_CTRL, 32'h161);
        fork host_u.pulse(1'b0, 40); watch(60, c, s); join
        check(32'(c >= 5), 1);
        watch(30, c, s);
        check(c, 0);
        wr(SSDC_ADR_CTRL, 32'h55);
        fork host_u.pulse(1'b0, 40); watch(60, c, s); join
        check(32'(c >= 10 && c <= 11), 1);
        wr(SSDC_ADR_CTRL, 32'h71);
        watch(4, c, s);
        watch(16, c, s);
        check(c, 4);
        check(32'(host_u.hung), 0);
        print_verdict;
    end
endmodule // ssdc_top_test
`default_nettype wire

//--- verilog/ssdc_pkg.sv
// Purpose: Shared constants for the sync and reference divider control block.
// Assumes: Wishbone classic slave with 32-bit data and word-aligned registers.
// Notes:   Register offsets, field positions and the control, power and rate reset values live here.
package ssdc_pkg;
    // Register byte offsets.
    localparam logic [7:0] SSDC_ADR_CTRL   = 8'h00;
    localparam logic [7:0] SSDC_ADR_POWER  = 8'h04;
    localparam logic [7:0] SSDC_ADR_BLOCK  = 8'h08;
    localparam logic [7:0] SSDC_ADR_BURST  = 8'h0C;
    localparam logic [7:0] SSDC_ADR_PAIRS  = 8'h10;
    localparam logic [7:0] SSDC_ADR_STATUS = 8'h14;
    localparam logic [7:0] SSDC_ADR_RATE   = 8'h18;
    // Control register fields.
    localparam int SSDC_CTRL_EN       = 0;
    localparam int SSDC_CTRL_POL      = 1;
    localparam int SSDC_CTRL_MODE_LO  = 2;
    localparam int SSDC_CTRL_SRC_LO   = 4;
    localparam int SSDC_CTRL_ROUTE_LO = 6;
    localparam int SSDC_CTRL_REQ      = 8;
    localparam int SSDC_CTRL_SHOT     = 9;
    localparam int SSDC_CTRL_CLR      = 10;
    // Power register fields.
    localparam int SSDC_PWR_BLOCK = 0;
    localparam int SSDC_PWR_GEN   = 1;
    localparam int SSDC_PWR_GDLY  = 2;
    // Reset values.
    localparam logic [31:0] SSDC_CTRL_RST  = 32'h0000_0440;
    localparam logic [31:0] SSDC_POWER_RST = 32'h0000_0007;
    localparam logic [15:0] SSDC_RATE_RST  = 16'h0008;
    // Source and route select codes.
    localparam logic [1:0] SSDC_SRC_PIN   = 2'h0;
    localparam logic [1:0] SSDC_SRC_RECLK = 2'h1;
    localparam logic [1:0] SSDC_SRC_GEN   = 2'h2;
    localparam logic [1:0] SSDC_SRC_CONT  = 2'h3;
    localparam logic [1:0] SSDC_ROUTE_SYNC = 2'h0;
    // Unmapped reads return this value.
    localparam logic [31:0] SSDC_UNMAPPED = 32'h0000_0000;
endpackage : ssdc_pkg

//--- verilog/ssdc_top.sv
// Purpose: Selects the sync or reference source and resets output dividers with it.
// Assumes: clk_i is the distribution clock; pins arrive asynchronously.
// Notes:   Registers over Wishbone classic; ack comes one cycle after the request.
`timescale 1ns/100ps
`default_nettype none
module ssdc_top
    import ssdc_pkg::*;
#(
    parameter int NPAIRS = 7
) (
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone classic slave.
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [7:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // External pins.
    input  wire logic              sync_pin_i,
    input  wire logic              reference_input_zero_i,
    input  wire logic              dist_clk_active_i,
    // Divider side.
    output logic [NPAIRS-1:0]      pair_divider_reset_o,
    output logic                   ref_divider_reset_o,
    output logic                   ref_divider_tick_o,
    output logic                   sync_path_o,
    output logic                   ref_out_o,
    output logic [NPAIRS-1:0]      pair_ref_out_o,
    output logic                   ref_delay_buffer_clear_o
);
    if (NPAIRS < 1 || NPAIRS > 16) begin : g_bad_npairs
        $error("NPAIRS must be 1 to 16.");
    end

    logic [31:0]       ctrl;
    logic [31:0]       power;
    logic [31:0]       block;
    logic [1:0]        burst_length_field;
    logic [NPAIRS-1:0] pair_output_source_select;
    logic [NPAIRS-1:0] pair_ref_out_powerdown;
    logic [15:0]       ref_rate;
    logic              burst_write;

    wire logic       enable_sync        = ctrl[SSDC_CTRL_EN];
    wire logic       trigger_polarity   = ctrl[SSDC_CTRL_POL];
    wire logic [1:0] sync_mode          = ctrl[SSDC_CTRL_MODE_LO +: 2];
    wire logic [1:0] ref_source_select  = ctrl[SSDC_CTRL_SRC_LO +: 2];
    wire logic [1:0] input0_route_select = ctrl[SSDC_CTRL_ROUTE_LO +: 2];
    wire logic       external_request_gate = ctrl[SSDC_CTRL_REQ];
    wire logic       ref_block_powerdown = power[SSDC_PWR_BLOCK];
    wire logic       burst_gen_powerdown = power[SSDC_PWR_GEN];
    wire logic       global_ref_delay_powerdown = power[SSDC_PWR_GDLY];
    wire logic [NPAIRS-1:0] pair_divider_resync_block = block[NPAIRS-1:0];
    wire logic       ref_divider_resync_block = block[16];

    // Bus slave: one-cycle ack, writes land on the acked edge.
    wire logic bus_req = cyc_i && stb_i && !ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req;
        end
    end

    function automatic logic [31:0] ssdc_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    wire logic wr = cyc_i && stb_i && ack_o && we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl                      <= SSDC_CTRL_RST;
            power                     <= SSDC_POWER_RST;
            block                     <= '1;
            burst_length_field        <= 2'h0;
            pair_output_source_select <= '0;
            pair_ref_out_powerdown    <= '1;
            ref_rate                  <= SSDC_RATE_RST;
            burst_write               <= 1'b0;
        end else begin
            burst_write <= 1'b0;
            if (wr) begin
                case (adr_i)
                    SSDC_ADR_CTRL:  ctrl  <= ssdc_merge(ctrl, dat_i, sel_i);
                    SSDC_ADR_POWER: power <= ssdc_merge(power, dat_i, sel_i);
                    SSDC_ADR_BLOCK: block <= ssdc_merge(block, dat_i, sel_i);
                    SSDC_ADR_BURST: begin
                        if (sel_i[0]) begin
                            burst_length_field <= dat_i[1:0];
                            burst_write        <= 1'b1;
                        end
                    end
                    SSDC_ADR_PAIRS: begin
                        if (sel_i[1:0] == 2'b11) begin
                            pair_output_source_select <= dat_i[NPAIRS-1:0];
                        end
                        if (sel_i[3:2] == 2'b11) begin
                            pair_ref_out_powerdown <= dat_i[16 +: NPAIRS];
                        end
                    end
                    SSDC_ADR_RATE: begin
                        if (sel_i[1:0] == 2'b11 && dat_i[15:0] >= 16'd2) begin
                            ref_rate <= dat_i[15:0];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Pin synchronisers.
    logic [1:0] pin_meta;
    logic [1:0] in0_meta;
    logic [1:0] act_meta;
    logic       pin_prev;
    logic       pol_prev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta <= 2'b00;
            in0_meta <= 2'b00;
            act_meta <= 2'b00;
            pin_prev <= 1'b0;
            pol_prev <= 1'b0;
        end else begin
            pin_meta <= {pin_meta[0], sync_pin_i};
            in0_meta <= {in0_meta[0], reference_input_zero_i};
            act_meta <= {act_meta[0], dist_clk_active_i};
            pin_prev <= pin_meta[1];
            pol_prev <= trigger_polarity;
        end
    end

    wire logic pin_s     = pin_meta[1];
    wire logic clk_ok    = act_meta[1];
    wire logic pin_level = pin_s ^ trigger_polarity;
    wire logic pol_toggle = trigger_polarity != pol_prev;
    wire logic pin_edge  = pin_s != pin_prev;

    // Reference divider: pulse train restarted by ref_divider_reset_o, about half duty.
    logic [15:0] ref_cnt;
    logic        ref_wave;
    wire logic   ref_wrap = (ref_cnt == ref_rate - 16'd1);

    always_ff @(posedge clk_i) begin
        if (rst_i || ref_block_powerdown) begin
            ref_cnt  <= 16'h0000;
            ref_wave <= 1'b0;
        end else if (ref_divider_reset_o) begin
            ref_cnt  <= 16'h0000;
            ref_wave <= 1'b0;
        end else begin
            ref_cnt  <= ref_wrap ? 16'h0000 : ref_cnt + 16'd1;
            ref_wave <= (ref_cnt < (ref_rate >> 1));
        end
    end

    wire logic period_end = ref_wrap && !ref_block_powerdown;

    // Burst generator and request streaming.
    logic [3:0] burst_left;
    logic       burst_run;
    logic       streaming;
    logic       burst_trig;

    always_comb begin
        burst_trig = 1'b0;
        if (sync_mode == 2'd2 && ref_source_select == SSDC_SRC_GEN) begin
            burst_trig = pin_edge || pol_toggle;
        end else if (sync_mode == 2'd3 && ref_source_select == SSDC_SRC_GEN) begin
            burst_trig = burst_write;
        end
        if (burst_gen_powerdown) begin
            burst_trig = 1'b0;
        end
    end

    // A burst runs whole reference periods only, so no pulse is cut or lost.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            burst_left <= 4'h0;
            burst_run  <= 1'b0;
        end else if (burst_trig && burst_left == 4'h0) begin
            burst_left <= 4'h1 << burst_length_field;
        end else if (period_end) begin
            if (burst_run) begin
                burst_left <= burst_left - 4'h1;
            end
            burst_run <= burst_run ? (burst_left > 4'h1) : (burst_left != 4'h0);
        end
    end

    wire logic req_mode = sync_mode == 2'd0 && ref_source_select == SSDC_SRC_GEN
                          && external_request_gate;

    // Stream starts and stops only at period boundaries.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            streaming <= 1'b0;
        end else if (period_end || ref_cnt == 16'h0000) begin
            if (ref_cnt == 16'h0000) begin
                streaming <= streaming || (req_mode && pin_s);
            end else begin
                streaming <= req_mode && pin_s;
            end
        end
    end

    // Source selection onto the single path.
    logic next_path;

    always_comb begin
        next_path = 1'b0;
        if (input0_route_select == SSDC_ROUTE_SYNC &&
            (ref_source_select == SSDC_SRC_PIN || ref_source_select == SSDC_SRC_RECLK)) begin
            next_path = in0_meta[1];
        end else begin
            case ({sync_mode, ref_source_select})
                {2'd0, SSDC_SRC_PIN}:   next_path = 1'b0;
                {2'd1, SSDC_SRC_PIN}:   next_path = pin_level || pol_toggle;
                {2'd1, SSDC_SRC_RECLK}: next_path = ref_wave && pin_level;
                {2'd2, SSDC_SRC_GEN},
                {2'd3, SSDC_SRC_GEN}:   next_path = burst_run && ref_wave;
                {2'd0, SSDC_SRC_GEN}:   next_path = streaming && ref_wave;
                default:                next_path = 1'b0;
            endcase
            if (ref_source_select == SSDC_SRC_CONT) begin
                next_path = ref_wave && !global_ref_delay_powerdown;
            end
        end
        if (!clk_ok) begin
            next_path = 1'b0;
        end
    end

    // Divider resets and outputs, except the divider tick, fed from one reclocked path.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_path_o          <= 1'b0;
            pair_divider_reset_o <= '0;
            ref_divider_reset_o  <= 1'b0;
            ref_divider_tick_o   <= 1'b0;
            ref_out_o            <= 1'b0;
            pair_ref_out_o       <= '0;
        end else begin
            sync_path_o          <= next_path;
            pair_divider_reset_o <= (enable_sync && next_path) ?
                                    ~pair_divider_resync_block : '0;
            ref_divider_reset_o  <= enable_sync && next_path &&
                                    !ref_divider_resync_block;
            ref_divider_tick_o   <= period_end;
            ref_out_o            <= next_path && !ref_block_powerdown;
            pair_ref_out_o       <= pair_output_source_select & ~pair_ref_out_powerdown
                                    & {NPAIRS{next_path}};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_delay_buffer_clear_o <= 1'b1;
        end else begin
            ref_delay_buffer_clear_o <= ctrl[SSDC_CTRL_CLR];
        end
    end

    // Read mux.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (bus_req && !we_i) begin
            case (adr_i)
                SSDC_ADR_CTRL:   dat_o <= ctrl;
                SSDC_ADR_POWER:  dat_o <= power;
                SSDC_ADR_BLOCK:  dat_o <= block;
                SSDC_ADR_BURST:  dat_o <= {30'h0, burst_length_field};
                SSDC_ADR_PAIRS:  dat_o <= {16'(pair_ref_out_powerdown),
                                           16'(pair_output_source_select)};
                SSDC_ADR_STATUS: dat_o <= {26'h0, clk_ok, streaming, burst_left};
                SSDC_ADR_RATE:   dat_o <= {16'h0, ref_rate};
                default:         dat_o <= SSDC_UNMAPPED;
            endcase
        end
    end
endmodule // ssdc_top
`default_nettype wire
